// ==== rlf_pkg.sv ====
package rlf_pkg;

  localparam int          DW              = 40;
  localparam int          CTLW            = 5;
  localparam int          LANES           = 5;
  localparam logic [7:0]  COMMA_BYTE      = 8'hbc;
  localparam logic [4:0]  COMMA_KCHAR     = 5'h01;
  localparam logic [3:0]  LAST_WORD       = 4'hf;
  localparam logic [7:0]  LAST_FRAME      = 8'hff;
  localparam logic [7:0]  LAST_HYPER      = 8'h95;
  localparam logic [5:0]  NS_SYNC         = 6'h00;
  localparam logic [5:0]  NS_SLOW         = 6'h01;
  localparam logic [5:0]  NS_L1           = 6'h02;
  localparam logic [5:0]  NS_VENDOR       = 6'h10;
  localparam logic [1:0]  XS_COMMA        = 2'h0;
  localparam logic [1:0]  XS_HFN          = 2'h1;
  localparam logic [1:0]  XS_BFN_LO       = 2'h2;
  localparam logic [1:0]  XS_BFN_HI       = 2'h3;
  localparam int          L1_RATE_LSB     = 8;
  localparam int          L1_HDLC_LSB     = 16;
  localparam logic [1:0]  RATE_614        = 2'h0;
  localparam logic [1:0]  RATE_1228       = 2'h1;
  localparam logic [1:0]  RATE_2457       = 2'h2;
  localparam logic [1:0]  RATE_3072       = 2'h3;

  localparam int          STEP_TIME_NS    = 10000;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam logic [10:0] STEP_CYCLES     = 11'(STEP_TIME_NS / CLK_PERIOD_NS);
  localparam logic [10:0] SIM_STEP_CYCLES = 11'h008;

  localparam int          ETH_AW          = 4;
  localparam logic [4:0]  ETH_DEPTH       = 5'h10;
  localparam logic [4:0]  ETH_ALMOST_FULL = 5'h0c;
  localparam logic [5:0]  ETH_PTR_RESET   = 6'h14;

  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_INIT       = 8'h04;
  localparam logic [7:0]  ADDR_ETH_PTR    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
  localparam logic [7:0]  ADDR_RX_POS     = 8'h10;
  localparam logic [7:0]  ADDR_L1         = 8'h14;
  localparam int          CTRL_W          = 13;
  localparam logic [12:0] CTRL_RESET      = 13'h0000;
  localparam int          CTRL_ROLE       = 0;
  localparam int          CTRL_SPEEDUP    = 1;
  localparam int          CTRL_HOLD       = 2;
  localparam int          CTRL_AUTO       = 3;
  localparam int          CTRL_HYP_RST    = 4;
  localparam int          CTRL_BFN_RST    = 5;
  localparam int          CTRL_HDLC_LSB   = 6;
  localparam int          CTRL_LBR_LSB    = 11;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_SYNC    = 3'b001,
    ST_PROTO   = 3'b010,
    ST_CM      = 3'b011,
    ST_IFVN    = 3'b100,
    ST_OPER    = 3'b101
  } rlf_state_t;

  typedef struct packed {
    logic reset_handshake;
    logic remote_alarm;
    logic access_defect;
  } rlf_l1_t;

  typedef struct packed {
    logic [7:0]  hyper;
    logic [11:0] node;
    logic [7:0]  frame;
  } rlf_frame_pos_t;

endpackage : rlf_pkg

// ==== rlf_framer.sv ====
// Summary of operation
// - role bit one selects controller end
// - speedup bit shortens start-up step timers
// - each ethernet fifo has own clear
// - hdlc rate enables limit offered rate
// - manual count uses init values for Z
// - sync with enable loads hyperframe counter
// - sync with enable loads node frame counter
// - rate code maps to line rate
// - hold bit forces start-up into standby
// - agreed line rate reported after start-up
// - radio end drives transmit disable
// - start-up status encodes states zero to five
// - receive outputs hyper, node, frame numbers
// - receive samples come with strobe, slot
// - request asks user for vendor word
// - almost full warns ethernet writer, only full blocks writes
// - receive fifo errors on two-bit flag
// - slip on any k char that is not a comma in low byte
// - subchannels zero, one, two fixed content
// - sixteen forty-bit words per basic frame
// - l1 bits inserted and received out
// - used sample width follows line rate
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rlf_framer
  import rlf_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                txrst,
  input  wire logic                rxrst,
  input  wire logic                tx_sync,
  input  wire logic [DW-1:0]       tx_sample_word,
  input  wire logic [DW-1:0]       tx_vendor_word,
  output logic                     vendor_word_request,
  input  wire logic                tx_hdlc_bit,
  input  wire logic [3:0]          tx_eth_nibble,
  input  wire logic                tx_eth_wr,
  output logic                     tx_eth_almost_full,
  input  wire logic                rx_eth_rd,
  output logic      [3:0]          rx_eth_nibble,
  output logic                     rx_eth_empty,
  output logic      [1:0]          rx_eth_fifo_err,
  output logic      [DW-1:0]       tx_line_word,
  output logic      [CTLW-1:0]     tx_line_kchar,
  input  wire logic [DW-1:0]       rx_line_word,
  input  wire logic [CTLW-1:0]     rx_line_kchar,
  output logic                     link_slip_request,
  output logic      [DW-1:0]       rx_sample_word,
  output logic                     rx_sample_strobe,
  output logic      [3:0]          rx_sample_slot_index,
  output rlf_frame_pos_t           rx_frame_pos,
  output rlf_l1_t                  rx_l1,
  output logic      [1:0]          rate_mode,
  output logic      [2:0]          startup_status,
  output logic                     tx_disable
);

  // ---------------- register file
  logic [CTRL_W-1:0] ctrl_q;
  logic [19:0]       init_q;
  logic [5:0]        eth_ptr_q;
  rlf_l1_t           l1_tx_q;
  logic              pready_q, pslverr_q;
  logic [31:0]       prdata_q;
  rlf_state_t        state_q, state_d;
  logic [10:0]       timer_q;
  logic [1:0]        rate_mode_q, remote_rate_q;
  logic [2:0]        hdlc_mode_q, remote_hdlc_q;
  logic              lock_q, tx_disable_q;
  rlf_frame_pos_t    rx_pos_q;
  rlf_l1_t           rx_l1_q;

  wire       role       = ctrl_q[CTRL_ROLE];
  wire       speedup    = ctrl_q[CTRL_SPEEDUP];
  wire       hold_idle  = ctrl_q[CTRL_HOLD];
  wire       auto_cnt   = ctrl_q[CTRL_AUTO];
  wire       hyp_rst_en = ctrl_q[CTRL_HYP_RST];
  wire       bfn_rst_en = ctrl_q[CTRL_BFN_RST];
  wire [4:0] hdlc_en    = ctrl_q[CTRL_HDLC_LSB +: 5];
  wire [1:0] lbr_en     = ctrl_q[CTRL_LBR_LSB +: 2];
  wire [7:0] hfn_init   = init_q[7:0];
  wire [11:0] bfn_init  = init_q[19:8];

  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_init = (paddr == ADDR_INIT);
  wire sel_ptr  = (paddr == ADDR_ETH_PTR);
  wire sel_stat = (paddr == ADDR_STATUS);
  wire sel_pos  = (paddr == ADDR_RX_POS);
  wire sel_l1   = (paddr == ADDR_L1);
  wire addr_hit = sel_ctrl | sel_init | sel_ptr | sel_stat | sel_pos | sel_l1;
  // one wait state: the answer is flopped, the write lands on the completing edge
  wire apb_access = psel & penable & ~pready_q;
  wire apb_write  = psel & penable & pready_q & pwrite & ~pslverr_q;

  wire [31:0] rd_mux =
    sel_ctrl ? {19'h0, ctrl_q} :
    sel_init ? {12'h0, init_q} :
    sel_ptr  ? {26'h0, eth_ptr_q} :
    sel_stat ? {22'h0, tx_disable_q, lock_q, hdlc_mode_q, rate_mode_q, state_q} :
    sel_pos  ? {4'h0, rx_pos_q} :
    sel_l1   ? {21'h0, rx_l1_q, 5'h0, l1_tx_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= apb_access;
      pslverr_q <= apb_access & ~addr_hit;
      prdata_q  <= (apb_access & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RESET;
      init_q    <= 20'h0;
      eth_ptr_q <= ETH_PTR_RESET;
      l1_tx_q   <= '0;
    end else if (apb_write) begin
      if (sel_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
      if (sel_init) init_q <= pwdata[19:0];
      if (sel_ptr) eth_ptr_q <= pwdata[5:0];
      if (sel_l1) l1_tx_q <= pwdata[2:0];
    end
  end
  // ---------------- sample lane mask
  wire [2:0] lanes_used = (rate_mode_q == RATE_3072) ? 3'h5 :
                          (rate_mode_q == RATE_2457) ? 3'h4 :
                          (rate_mode_q == RATE_1228) ? 3'h2 : 3'h1;
  logic [DW-1:0] lane_mask;
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{3'(gi) < lanes_used}};
    end
  endgenerate
  // ---------------- transmit framing
  logic [3:0]  tw_q;
  logic [7:0]  tfrm_q, thyp_q;
  logic [11:0] tbfn_q;
  wire [5:0] t_ns  = tfrm_q[5:0];
  wire [1:0] t_xs  = tfrm_q[7:6];
  wire       t_ctl = (tw_q == 4'h0);
  wire       t_eth = t_ctl & (eth_ptr_q != 6'h0) & (t_ns >= eth_ptr_q);
  wire       t_vnd = t_ctl & (t_ns >= NS_VENDOR) & ~t_eth;
  wire [3:0] tn_w   = tx_sync ? 4'h0 : tw_q + 4'h1;
  wire [7:0] tn_frm = tx_sync ? 8'h0 : ((tw_q == LAST_WORD) ? tfrm_q + 8'h1 : tfrm_q);
  wire       tn_vnd = (tn_w == 4'h0) & (tn_frm[5:0] >= NS_VENDOR) &
                      ~((eth_ptr_q != 6'h0) & (tn_frm[5:0] >= eth_ptr_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_q   <= 4'h0;
      tfrm_q <= 8'h0;
      thyp_q <= 8'h0;
      tbfn_q <= 12'h0;
    end else if (tx_sync) begin
      tw_q   <= 4'h0;
      tfrm_q <= 8'h0;
      thyp_q <= (auto_cnt & hyp_rst_en) ? hfn_init : 8'h0;
      tbfn_q <= (auto_cnt & bfn_rst_en) ? bfn_init : tbfn_q + 12'h1;
    end else begin
      tw_q <= tw_q + 4'h1;
      if (tw_q == LAST_WORD) begin
        tfrm_q <= tfrm_q + 8'h1;
        if (tfrm_q == LAST_FRAME) begin
          thyp_q <= (thyp_q == LAST_HYPER) ? 8'h0 : thyp_q + 8'h1;
          if (thyp_q == LAST_HYPER) tbfn_q <= tbfn_q + 12'h1;
        end
      end
    end
  end
  // radio end follows the controller's timing, controller uses own or loaded values
  wire [7:0]  z_hfn = role ? (auto_cnt ? thyp_q : hfn_init) : rx_pos_q.hyper;
  wire [11:0] z_bfn = role ? (auto_cnt ? tbfn_q : bfn_init) : rx_pos_q.node;
  wire [2:0] hdlc_cap = hdlc_en[4] ? 3'h5 : hdlc_en[3] ? 3'h4 : hdlc_en[2] ? 3'h3 :
                        hdlc_en[1] ? 3'h2 : hdlc_en[0] ? 3'h1 : 3'h0;
  wire [DW-1:0] l1_word = DW'({hdlc_cap, 6'h0, lbr_en, 5'h0, l1_tx_q});
  logic [3:0]        tx_mem [0:ETH_DEPTH-1];
  logic [ETH_AW:0]   tx_wp_q, tx_rp_q;
  wire               tx_full  = ((tx_wp_q - tx_rp_q) == ETH_DEPTH);
  wire               tx_empty = (tx_wp_q == tx_rp_q);
  wire               tx_push  = tx_eth_wr & ~tx_full;
  wire               tx_pop   = t_eth & ~tx_empty;
  wire [ETH_AW:0]    tx_wp_d  = txrst ? 5'h0 : tx_wp_q + {4'h0, tx_push};
  wire [ETH_AW:0]    tx_rp_d  = txrst ? 5'h0 : tx_rp_q + {4'h0, tx_pop};
  wire [ETH_AW:0]    tx_cnt_d = tx_wp_d - tx_rp_d;
  wire [3:0]         tx_head  = tx_empty ? 4'h0 : tx_mem[tx_rp_q[ETH_AW-1:0]];
  wire [DW-1:0] t_word =
    ~t_ctl ? (tx_sample_word & lane_mask) :
    (t_ns == NS_SYNC) ? ((t_xs == XS_COMMA) ? DW'(COMMA_BYTE) :
                         (t_xs == XS_HFN)   ? DW'(z_hfn) :
                         (t_xs == XS_BFN_LO) ? DW'(z_bfn[7:0]) : DW'(z_bfn[11:8])) :
    (t_ns == NS_SLOW) ? DW'(tx_hdlc_bit & (hdlc_mode_q != 3'h0)) :
    ((t_ns == NS_L1) & (t_xs == XS_COMMA)) ? l1_word :
    t_vnd ? tx_vendor_word :
    t_eth ? DW'(tx_head) : '0;
  wire [CTLW-1:0] t_kchar = (t_ctl & (t_ns == NS_SYNC) & (t_xs == XS_COMMA)) ? COMMA_KCHAR : '0;

  always_ff @(posedge pclk) begin
    if (tx_push) tx_mem[tx_wp_q[ETH_AW-1:0]] <= tx_eth_nibble;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_q         <= 5'h0;
      tx_rp_q         <= 5'h0;
      tx_eth_almost_full <= 1'b0;
      tx_line_word    <= '0;
      tx_line_kchar   <= '0;
      vendor_word_request <= 1'b0;
    end else begin
      tx_wp_q         <= tx_wp_d;
      tx_rp_q         <= tx_rp_d;
      tx_eth_almost_full <= (tx_cnt_d >= ETH_ALMOST_FULL);
      tx_line_word    <= t_word;
      tx_line_kchar   <= t_kchar;
      vendor_word_request <= tn_vnd;
    end
  end
  // ---------------- receive deframing
  logic [3:0] rw_q;
  logic [7:0] rfrm_q;
  wire        comma = rx_line_kchar[0] & (rx_line_word[7:0] == COMMA_BYTE);
  wire [3:0]  r_w   = comma ? 4'h0 : rw_q;
  wire [7:0]  r_frm = comma ? 8'h0 : rfrm_q;
  wire [5:0]  r_ns  = r_frm[5:0];
  wire [1:0]  r_xs  = r_frm[7:6];
  wire        r_ctl = (r_w == 4'h0);
  wire        r_eth = lock_q & r_ctl & (eth_ptr_q != 6'h0) & (r_ns >= eth_ptr_q);

  logic [3:0]      rx_mem [0:ETH_DEPTH-1];
  logic [ETH_AW:0] rx_wp_q, rx_rp_q;
  wire             rx_full  = ((rx_wp_q - rx_rp_q) == ETH_DEPTH);
  wire             rx_emp   = (rx_wp_q == rx_rp_q);
  wire             rx_push  = r_eth & ~rx_full;
  wire             rx_pop   = rx_eth_rd & ~rx_emp;
  wire [ETH_AW:0]  rx_wp_d  = rxrst ? 5'h0 : rx_wp_q + {4'h0, rx_push};
  wire [ETH_AW:0]  rx_rp_d  = rxrst ? 5'h0 : rx_rp_q + {4'h0, rx_pop};
  // set wins over the clear so an error in the clearing cycle is kept
  wire [1:0]       rx_err_set = {r_eth & rx_full, rx_eth_rd & rx_emp};

  always_ff @(posedge pclk) begin
    if (rx_push) rx_mem[rx_wp_q[ETH_AW-1:0]] <= rx_line_word[3:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rw_q   <= 4'h0;
      rfrm_q <= 8'h0;
      lock_q <= 1'b0;
      link_slip_request <= 1'b0;
    end else begin
      rw_q   <= r_w + 4'h1;
      rfrm_q <= (r_w == LAST_WORD) ? r_frm + 8'h1 : r_frm;
      if (comma) lock_q <= 1'b1;
      else if (r_ctl & (r_frm == 8'h0)) lock_q <= 1'b0;
      link_slip_request <= ~comma & (rx_line_kchar != '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_q          <= 5'h0;
      rx_rp_q          <= 5'h0;
      rx_eth_empty     <= 1'b1;
      rx_eth_nibble    <= 4'h0;
      rx_eth_fifo_err  <= 2'h0;
      rx_sample_strobe <= 1'b0;
      rx_sample_word   <= '0;
      rx_sample_slot_index <= 4'h0;
      rx_pos_q         <= '0;
      rx_l1_q          <= '0;
      remote_rate_q    <= RATE_614;
      remote_hdlc_q    <= 3'h0;
    end else begin
      rx_wp_q         <= rx_wp_d;
      rx_rp_q         <= rx_rp_d;
      rx_eth_empty    <= (rx_wp_d == rx_rp_d);
      if (rx_pop) rx_eth_nibble <= rx_mem[rx_rp_q[ETH_AW-1:0]];
      rx_eth_fifo_err <= (rx_eth_fifo_err & {2{~rxrst}}) | rx_err_set;
      rx_sample_strobe <= lock_q & ~r_ctl;
      if (lock_q & ~r_ctl) begin
        rx_sample_word       <= rx_line_word & lane_mask;
        rx_sample_slot_index <= r_w;
        rx_pos_q.frame       <= r_frm;
      end
      if (lock_q & r_ctl & (r_ns == NS_SYNC)) begin
        if (r_xs == XS_HFN) rx_pos_q.hyper <= rx_line_word[7:0];
        if (r_xs == XS_BFN_LO) rx_pos_q.node[7:0] <= rx_line_word[7:0];
        if (r_xs == XS_BFN_HI) rx_pos_q.node[11:8] <= rx_line_word[3:0];
      end
      if (lock_q & r_ctl & (r_ns == NS_L1) & (r_xs == XS_COMMA)) begin
        rx_l1_q       <= rx_line_word[2:0];
        remote_rate_q <= rx_line_word[L1_RATE_LSB +: 2];
        remote_hdlc_q <= rx_line_word[L1_HDLC_LSB +: 3];
      end
    end
  end
  // ---------------- start-up sequence
  wire [10:0] step_len = speedup ? SIM_STEP_CYCLES : STEP_CYCLES;
  wire        step_done = (timer_q >= step_len - 11'h1);
  wire [1:0]  rate_agree = (lbr_en < remote_rate_q) ? lbr_en : remote_rate_q;
  wire [2:0]  hdlc_agree = (hdlc_cap < remote_hdlc_q) ? hdlc_cap : remote_hdlc_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: state_d = ST_SYNC;
      ST_SYNC:    if (lock_q) state_d = ST_PROTO;
      ST_PROTO:   if (step_done) state_d = ST_CM;
      ST_CM:      if (step_done) state_d = ST_IFVN;
      ST_IFVN:    if (step_done) state_d = ST_OPER;
      ST_OPER:    state_d = ST_OPER;
      default:    state_d = ST_STANDBY;
    endcase
    if ((state_q != ST_STANDBY) && (state_q != ST_SYNC) && !lock_q) state_d = ST_SYNC;
    if (hold_idle) state_d = ST_STANDBY;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_STANDBY;
      timer_q      <= 11'h0;
      rate_mode_q  <= RATE_614;
      hdlc_mode_q  <= 3'h0;
      tx_disable_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= (state_d != state_q) ? 11'h0 : timer_q + {10'h0, ~step_done};
      if ((state_q == ST_PROTO) && (state_d == ST_CM)) begin
        rate_mode_q <= rate_agree;
        hdlc_mode_q <= hdlc_agree;
      end
      tx_disable_q <= ~role & ((state_d == ST_STANDBY) | (state_d == ST_SYNC));
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign rx_frame_pos   = rx_pos_q;
  assign rx_l1          = rx_l1_q;
  assign rate_mode      = rate_mode_q;
  assign startup_status = state_q;
  assign tx_disable     = tx_disable_q;
  // ---------------- checks
  AST_ROLE_TXDIS: assert property (@(posedge pclk) disable iff (!presetn)
    tx_disable |-> !$past(role)) else $error("transmit disabled on controller end");
  AST_HOLD_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    hold_idle |=> (startup_status == ST_STANDBY)) else $error("hold did not force standby");
  AST_Z64_MANUAL: assert property (@(posedge pclk) disable iff (!presetn)
    (role & !auto_cnt & t_ctl & (t_ns == NS_SYNC) & (t_xs == XS_HFN))
    |=> (tx_line_word[7:0] == $past(hfn_init))) else $error("Z64 not taken from init");
  AST_HFN_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_sync & auto_cnt & hyp_rst_en) |=> (thyp_q == $past(hfn_init)))
    else $error("hyperframe counter not loaded");
  AST_BFN_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_sync & auto_cnt & bfn_rst_en) |=> (tbfn_q == $past(bfn_init)))
    else $error("node frame counter not loaded");
  AST_COMMA_TX: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn & !tx_sync & (tw_q == 4'h0) & (tfrm_q == 8'h0)) |=>
    ((tx_line_word[7:0] == COMMA_BYTE) && tx_line_kchar[0])) else $error("comma missing");
  AST_SLIP: assert property (@(posedge pclk) disable iff (!presetn)
    comma |=> !link_slip_request) else $error("slip while comma aligned");
  AST_STROBE_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
    rx_sample_strobe |-> (rx_sample_slot_index != 4'h0)) else $error("strobe on control slot");
  AST_ALMOST_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    ((tx_wp_q - tx_rp_q) >= ETH_ALMOST_FULL) |-> tx_eth_almost_full)
    else $error("almost full not shown");
  AST_RX_UNDERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_eth_rd & rx_emp) |=> rx_eth_fifo_err[0]) else $error("underflow not flagged");
  AST_VENDOR_REQ: assert property (@(posedge pclk) disable iff (!presetn)
    (vendor_word_request & !$past(tx_sync)) |-> t_vnd) else $error("request off vendor slot");

endmodule : rlf_framer

`default_nettype wire

// ==== rlf_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module rlf_line_model
  import rlf_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            bad_comma,
  input  wire logic [DW-1:0]   tx_line_word,
  input  wire logic [CTLW-1:0] tx_line_kchar,
  output logic      [DW-1:0]   rx_line_word,
  output logic      [CTLW-1:0] rx_line_kchar
);
  // front end loops the line back one word late; bad_comma marks a k char that is not the comma
  always_ff @(posedge pclk) begin
    rx_line_word  <= bad_comma ? {tx_line_word[DW-1:8], 8'h7c} : tx_line_word;
    rx_line_kchar <= bad_comma ? 5'h01 : tx_line_kchar;
  end
endmodule : rlf_line_model

`default_nettype wire

// ==== radio_link_l1_framer_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module radio_link_l1_framer_test;
  import rlf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic txrst = 0, rxrst = 0, tx_sync = 0, tx_eth_wr = 0, rx_eth_rd = 0, bad_comma = 0;
  logic tx_hdlc_bit = 0, vendor_word_request, tx_eth_almost_full, rx_eth_empty;
  logic link_slip_request, rx_sample_strobe, tx_disable;
  logic [7:0]      paddr = 0;
  logic [31:0]     pwdata = 0, prdata, r;
  logic [3:0]      tx_eth_nibble = 4'h5, rx_eth_nibble, rx_sample_slot_index;
  logic [1:0]      rx_eth_fifo_err, rate_mode;
  logic [2:0]      startup_status;
  logic [DW-1:0]   tx_sample_word = 40'hff_ffff_ffff, tx_vendor_word = 40'h12_3456_789a;
  logic [DW-1:0]   tx_line_word, rx_line_word, rx_sample_word;
  logic [CTLW-1:0] tx_line_kchar, rx_line_kchar;
  rlf_frame_pos_t  rx_frame_pos;
  rlf_l1_t         rx_l1;
  logic            e;
  int              err_total = 0, samples_checked = 0, cycles = 0;

  always #4 pclk = ~pclk;

  rlf_framer u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .txrst, .rxrst, .tx_sync, .tx_sample_word, .tx_vendor_word,
    .vendor_word_request, .tx_hdlc_bit, .tx_eth_nibble, .tx_eth_wr, .tx_eth_almost_full,
    .rx_eth_rd, .rx_eth_nibble, .rx_eth_empty, .rx_eth_fifo_err, .tx_line_word,
    .tx_line_kchar, .rx_line_word, .rx_line_kchar, .link_slip_request, .rx_sample_word,
    .rx_sample_strobe, .rx_sample_slot_index, .rx_frame_pos, .rx_l1, .rate_mode,
    .startup_status, .tx_disable);

  rlf_line_model u_line (.pclk, .bad_comma, .tx_line_word, .tx_line_kchar, .rx_line_word,
    .rx_line_kchar);

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // values seen right after an edge are the ones that edge sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) check(1, 0);
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic wait_oper();
    logic [2:0] prev;
    int n;
    prev = startup_status;
    n = 0;
    // bound is far below a normal step, so a dead speedup shows
    while (startup_status !== ST_OPER && n < 200) begin
      @(posedge pclk);
      n++;
      if (startup_status !== prev) begin
        check(startup_status, prev + 3'h1);
        prev = startup_status;
      end
    end
    check(startup_status, ST_OPER);
  endtask : wait_oper

  task automatic sync_pulse();
    @(posedge pclk);
    tx_sync <= 1;
    @(posedge pclk);
    tx_sync <= 0;
  endtask : sync_pulse

  task automatic t_regs();
    apb(0, ADDR_CTRL, 0);
    check(r, 32'h0);
    apb(0, ADDR_ETH_PTR, 0);
    check(r[5:0], ETH_PTR_RESET);
    apb(0, 8'h20, 32'hffff_ffff);
    check({e, r}, {1'b1, 32'h0});
  endtask : t_regs

  task automatic t_startup();
    apb(1, ADDR_CTRL, 32'h0000_0842);
    wait_oper();
    check(tx_disable, 0);
    apb(1, ADDR_CTRL, 32'h0000_0846);
    cyc(4);
    check({startup_status, tx_disable}, {ST_STANDBY, 1'b1});
    apb(1, ADDR_CTRL, 32'h0000_0842);
    wait_oper();
    // the far maximum is known only once its inband word has come back
    check(rate_mode, RATE_1228);
  endtask : t_startup

  task automatic t_frames();
    int n;
    sync_pulse();
    // word 0 is built on the edge after the pulse and shows one edge later
    cyc(2);
    check({tx_line_kchar, tx_line_word[7:0]}, {COMMA_KCHAR, COMMA_BYTE});
    cyc(16);
    check(tx_line_kchar, 5'h00);
    cyc(4080);
    check({tx_line_kchar, tx_line_word[7:0]}, {COMMA_KCHAR, COMMA_BYTE});
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rx_sample_strobe !== 1'b1 && n < 64);
    check(rx_sample_word, 40'h00_0000_ffff);
    check(rx_sample_slot_index == 4'h0, 0);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (vendor_word_request !== 1'b1 && n < 5000);
    check(vendor_word_request, 1);
  endtask : t_frames

  task automatic t_count();
    apb(1, ADDR_L1, 32'h0000_0006);
    cyc(8400);
    check(rx_l1, 3'b110);
    apb(0, ADDR_L1, 0);
    check(r[10:8], 3'b110);
    apb(1, ADDR_INIT, 32'h0003_4512);
    apb(1, ADDR_CTRL, 32'h0000_087b);
    sync_pulse();
    cyc(3300);
    check({rx_frame_pos.hyper, rx_frame_pos.node}, 20'h12345);
    apb(1, ADDR_CTRL, 32'h0000_0873);
    apb(1, ADDR_INIT, 32'h0003_4534);
    cyc(4300);
    check(rx_frame_pos.hyper, 8'h34);
  endtask : t_count

  task automatic t_eth();
    apb(1, ADDR_ETH_PTR, 0);
    tx_eth_wr <= 1;
    cyc(16);
    tx_eth_wr <= 0;
    @(posedge pclk);
    check(tx_eth_almost_full, 1);
    txrst <= 1;
    @(posedge pclk);
    txrst <= 0;
    rxrst <= 1;
    @(posedge pclk);
    rxrst <= 0;
    check(tx_eth_almost_full, 0);
    @(posedge pclk);
    check(rx_eth_fifo_err, 2'b00);
    rx_eth_rd <= 1;
    @(posedge pclk);
    rx_eth_rd <= 0;
    @(posedge pclk);
    check(rx_eth_fifo_err, 2'b01);
    bad_comma <= 1;
    cyc(3);
    check(link_slip_request, 1);
    bad_comma <= 0;
    cyc(4);
    check(link_slip_request, 0);
  endtask : t_eth

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    cyc(3);
    check({rx_eth_empty, startup_status, tx_disable}, 5'b10000);
    presetn <= 1;
    cyc(2);
    check(tx_disable, 1);
    t_regs();
    t_startup();
    t_frames();
    t_count();
    t_eth();
    final_report();
  end
endmodule : radio_link_l1_framer_test

`default_nettype wire
